// ==== pin_remap_and_change_notify_tb_top.sv ====
// Self-checking bench: a cycle model of the block is compared at every clock.
// Assumes the pad model file and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pin_remap_and_change_notify_tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic clr = 1'b0;
  prc_pkg::prc_map_wr_t i_map_wr = '0;
  prc_pkg::prc_lock_wr_t i_lock_wr = '0;
  logic [31:0] i_periph_out = '0;
  logic [24:0] ana = '0, dir = '1, gpo = '0, spe = '0, spo = '0, ext = '0;
  logic [24:0] pad_in, pad_out, oe_n, e_po, e_oe;
  logic [15:0] cel = '0, pul = '0, pin, e_pi;
  logic [14:0] ceh = '0, puh = '0;
  logic [30:0] cnp = '0, pu, e_pu, s1, s2, lat;
  logic flag, lock, e_fl, mlock;
  logic [2:0] fill;
  int om[25];
  int im[16];
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  prc_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_map_wr(i_map_wr),
    .i_lock_wr(i_lock_wr), .i_periph_out(i_periph_out), .o_periph_in(pin),
    .i_pad_in(pad_in), .i_analog_en(ana), .i_dir_in(dir), .i_gpio_out(gpo),
    .i_special_en(spe), .i_special_out(spo), .o_pad_out(pad_out), .o_pad_oe_n(oe_n),
    .i_cn_pad(cnp), .i_change_enable_low(cel), .i_change_enable_high(ceh),
    .i_pullup_enable_low(pul), .i_pullup_enable_high(puh), .i_cn_flag_clr(clr),
    .o_pullup_en(pu), .o_cn_flag(flag), .o_lock(lock));
  prc_pad_model pm_u (.i_pad_out(pad_out), .i_pad_oe_n(oe_n), .i_ext(ext), .o_pad(pad_in));

  initial begin
    forever #10 i_clk = ~i_clk;
  end

  task automatic close_out();
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      $display("ERROR %0t run did not finish", $time);
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Next expected outputs from the inputs set up for the coming edge
  task automatic model();
    logic h;
    if (i_rst) begin
      foreach (om[p]) om[p] = 0;
      foreach (im[j]) im[j] = 31;
      mlock = 1'b0;
      {e_po, e_oe, e_pi, e_pu, e_fl} = {25'h0, 25'h1ff_ffff, 16'h0, 31'h0, 1'b0};
      {s1, s2, lat, fill} = '0;
    end else if (i_ce) begin
      for (int p = 0; p < 25; p++) begin
        e_po[p] = spe[p] ? spo[p] : (om[p] != 0 ? i_periph_out[om[p]] : gpo[p]);
        e_oe[p] = spe[p] ? 1'b0 : dir[p];
      end
      for (int j = 0; j < 16; j++) begin
        e_pi[j] = (im[j] < 25 && !ana[im[j]]) ? pad_in[im[j]] : 1'b0;
      end
      // No change counts until the latched level holds a real pad sample
      h = fill[2] && |({ceh, cel} & (s2 ^ lat));
      e_fl = h | (e_fl & ~clr);
      {lat, s2, s1} = {s2, s1, cnp};
      fill = {fill[1:0], 1'b1};
      e_pu = {puh, pul};
      if (i_map_wr.we && !mlock) begin
        if (i_map_wr.to_input && i_map_wr.idx < 16) im[i_map_wr.idx] = i_map_wr.val;
        if (!i_map_wr.to_input && i_map_wr.idx < 25) om[i_map_wr.idx] = i_map_wr.val;
      end
      if (i_lock_wr.we) mlock = i_lock_wr.val;
    end
  endtask

  task automatic step();
    #1;
    model();
    @(posedge i_clk);
    @(negedge i_clk);
    chk(32'(pad_out), 32'(e_po), "pad data");
    chk(32'(oe_n), 32'(e_oe), "pad enable");
    chk(32'(pin), 32'(e_pi), "periph input");
    chk(32'(pu), 32'(e_pu), "pull-up");
    chk(32'(flag), 32'(e_fl), "change flag");
    chk(32'(lock), 32'(mlock), "lock");
  endtask

  task automatic rnd(input bit full);
    i_periph_out = $urandom;
    ext = 25'($urandom);
    dir = 25'($urandom);
    gpo = 25'($urandom);
    spo = 25'($urandom);
    ana = 25'($urandom & $urandom & $urandom);
    spe = 25'($urandom & $urandom & $urandom);
    if (full) begin
      i_map_wr = prc_pkg::prc_map_wr_t'(12'($urandom));
      i_lock_wr = {$urandom_range(0, 40) == 0, 1'($urandom)};
      i_ce = $urandom_range(0, 9) != 0;
      clr = $urandom_range(0, 7) == 0;
      {ceh, cel} = 31'($urandom);
      {puh, pul} = 31'($urandom);
      if ($urandom_range(0, 4) == 0) cnp[$urandom_range(0, 30)] ^= 1'b1;
    end
  endtask

  // Back-to-back writes keep the strobe up; the caller drops it afterwards
  task automatic wr(input bit ti, input int idx, input int val);
    rnd(1'b0);
    i_map_wr = {1'b1, ti, 5'(idx), 5'(val)};
    step();
  endtask

  initial begin
    void'($urandom(32'h3810_baf5));
    cnp = 31'($urandom);
    {ceh, cel} = 31'($urandom);
    repeat (2) step();
    i_rst = 1'b0;
    for (int p = 0; p < 25; p++) wr(1'b0, p, p + 1);
    for (int j = 0; j < 16; j++) wr(1'b1, j, 24 - j);
    i_map_wr = '0;
    i_lock_wr = 2'b11;
    step();
    i_lock_wr = '0;
    wr(1'b0, 3, 9);
    wr(1'b1, 0, 31);
    repeat (3000) begin
      rnd(1'b1);
      step();
    end
    i_rst = 1'b1;
    rnd(1'b1);
    step();
    i_rst = 1'b0;
    repeat (300) begin
      rnd(1'b1);
      step();
    end
    close_out();
  end
endmodule
`default_nettype wire

// ==== prc_cn_cell.sv ====
// Change-notice detector for a group of pins: synchroniser, latched level, hit.
// Assumes pads are asynchronous; the clock enable freezes every flop.
`timescale 1ns/1ps
`default_nettype none
module prc_cn_cell #(
  parameter int W = 16
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_ce, // Clock enable
  input wire logic [W-1:0] i_pad, // Pad levels
  input wire logic [W-1:0] i_en, // Change enables
  output logic [W-1:0] o_hit // Enabled mismatch
);
  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] last;
  logic seen1;
  logic seen2;
  logic primed;

  // Valid bits travel with the samples, so a pad held high through reset gives no false hit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1 <= '0;
      sync2 <= '0;
      seen1 <= 1'b0;
      seen2 <= 1'b0;
    end else if (i_ce) begin
      sync1 <= i_pad;
      sync2 <= sync1;
      seen1 <= 1'b1;
      seen2 <= seen1;
    end
  end

  // Latched level only moves with the clock, so a change made while stopped is seen later
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last <= '0;
      primed <= 1'b0;
    end else if (i_ce) begin
      last <= sync2;
      primed <= seen2;
    end
  end

  assign o_hit = primed ? (i_en & (sync2 ^ last)) : '0;
endmodule
`default_nettype wire

// ==== prc_pad_model.sv ====
// Pad model for the remappable pins: what the block reads back from its pins.
// Assumes the bench supplies the outside level of every pin the block releases.
`timescale 1ns/1ps
`default_nettype none
module prc_pad_model (
  input wire logic [prc_pkg::NUM_RP-1:0] i_pad_out, // Level driven by the block
  input wire logic [prc_pkg::NUM_RP-1:0] i_pad_oe_n, // Low while the block drives
  input wire logic [prc_pkg::NUM_RP-1:0] i_ext, // Outside level, set by the bench
  output logic [prc_pkg::NUM_RP-1:0] o_pad // Level seen at the pin
);
  // A driven pin reads its own level, a released pin shows the outside one
  assign o_pad = (i_pad_oe_n & i_ext) | (~i_pad_oe_n & i_pad_out);
endmodule
`default_nettype wire

// ==== prc_pkg.sv ====
// Constants, field layouts and carrier types for the pin remap and change-notice block.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
`default_nettype none
package prc_pkg;
  localparam int NUM_RP = 25;
  localparam int NUM_CN_LOW = 16;
  localparam int NUM_CN_HIGH = 15;
  localparam int NUM_CN = NUM_CN_LOW + NUM_CN_HIGH;
  localparam int NUM_PIN_IN = 16;
  localparam int NUM_PIN_OUT = 32;
  localparam int SEL_W = 5;
  localparam logic [SEL_W-1:0] IN_MAP_RST = 5'h1f;
  localparam logic [SEL_W-1:0] OUT_MAP_RST = 5'h00;
  localparam logic [SEL_W-1:0] OUT_NULL = 5'h00;
  localparam logic LOCK_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;

  typedef struct packed {
    logic we;
    logic to_input;
    logic [SEL_W-1:0] idx;
    logic [SEL_W-1:0] val;
  } prc_map_wr_t;

  typedef struct packed {
    logic we;
    logic val;
  } prc_lock_wr_t;
endpackage
`default_nettype wire

// ==== prc_top.sv ====
// Remappable pin selection with mapping lock, plus input change notification and pull-ups.
// Assumes all pad and peripheral inputs are synchronous to i_clk except the change pads.
`timescale 1ns/1ps
`default_nettype none
module prc_top (
  input wire logic i_clk, // System clock, 50 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_ce, // Clock enable, freezes state when low
  input wire prc_pkg::prc_map_wr_t i_map_wr, // Mapping field write
  input wire prc_pkg::prc_lock_wr_t i_lock_wr, // Lock bit write
  input wire logic [prc_pkg::NUM_PIN_OUT-1:0] i_periph_out, // Peripheral outputs by number
  output logic [prc_pkg::NUM_PIN_IN-1:0] o_periph_in, // Mapped peripheral inputs
  input wire logic [prc_pkg::NUM_RP-1:0] i_pad_in, // Remappable pad levels
  input wire logic [prc_pkg::NUM_RP-1:0] i_analog_en, // Analog function on pin
  input wire logic [prc_pkg::NUM_RP-1:0] i_dir_in, // Pin direction bit, 1 is input
  input wire logic [prc_pkg::NUM_RP-1:0] i_gpio_out, // Port or parallel port data
  input wire logic [prc_pkg::NUM_RP-1:0] i_special_en, // Fixed special output active
  input wire logic [prc_pkg::NUM_RP-1:0] i_special_out, // Fixed special output data
  output logic [prc_pkg::NUM_RP-1:0] o_pad_out, // Pad output data
  output logic [prc_pkg::NUM_RP-1:0] o_pad_oe_n, // Pad output enable, low drives
  input wire logic [prc_pkg::NUM_CN-1:0] i_cn_pad, // Change-notice pad levels
  input wire logic [prc_pkg::NUM_CN_LOW-1:0] i_change_enable_low, // Change enables, low
  input wire logic [prc_pkg::NUM_CN_HIGH-1:0] i_change_enable_high, // Change enables, high
  input wire logic [prc_pkg::NUM_CN_LOW-1:0] i_pullup_enable_low, // Pull-up enables, low
  input wire logic [prc_pkg::NUM_CN_HIGH-1:0] i_pullup_enable_high, // Pull-up enables, high
  input wire logic i_cn_flag_clr, // Clear change flag
  output logic [prc_pkg::NUM_CN-1:0] o_pullup_en, // Pull-up controls
  output logic o_cn_flag, // Change-notice interrupt request
  output logic o_lock // Mapping lock state
);
  localparam logic [prc_pkg::SEL_W-1:0] RP_LIMIT = 5'(prc_pkg::NUM_RP);

  logic [prc_pkg::SEL_W-1:0] in_map [prc_pkg::NUM_PIN_IN];
  logic [prc_pkg::SEL_W-1:0] out_map [prc_pkg::NUM_RP];
  logic [prc_pkg::NUM_PIN_IN-1:0] next_periph_in;
  logic [prc_pkg::NUM_RP-1:0] next_pad_out;
  logic [prc_pkg::NUM_RP-1:0] next_pad_oe_n;
  logic [prc_pkg::NUM_CN_LOW-1:0] hit_low;
  logic [prc_pkg::NUM_CN_HIGH-1:0] hit_high;
  logic [prc_pkg::NUM_CN-1:0] cn_hit;
  logic map_open;

  assign map_open = i_map_wr.we && !o_lock;

  // Lock bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_lock <= prc_pkg::LOCK_RST;
    end else if (i_ce && i_lock_wr.we) begin
      o_lock <= i_lock_wr.val;
    end
  end

  // Input mapping fields, one select per peripheral input
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int j = 0; j < prc_pkg::NUM_PIN_IN; j++) begin
        in_map[j] <= prc_pkg::IN_MAP_RST;
      end
    end else if (i_ce && map_open && i_map_wr.to_input) begin
      for (int j = 0; j < prc_pkg::NUM_PIN_IN; j++) begin
        if (i_map_wr.idx == 5'(j)) begin
          in_map[j] <= i_map_wr.val;
        end
      end
    end
  end

  // Output mapping fields, one select per remappable pin
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int p = 0; p < prc_pkg::NUM_RP; p++) begin
        out_map[p] <= prc_pkg::OUT_MAP_RST;
      end
    end else if (i_ce && map_open && !i_map_wr.to_input) begin
      for (int p = 0; p < prc_pkg::NUM_RP; p++) begin
        if (i_map_wr.idx == 5'(p)) begin
          out_map[p] <= i_map_wr.val;
        end
      end
    end
  end

  // A single select field per input means two pins can never claim it
  always_comb begin
    next_periph_in = '0;
    for (int j = 0; j < prc_pkg::NUM_PIN_IN; j++) begin
      if (in_map[j] < RP_LIMIT) begin
        next_periph_in[j] = i_pad_in[in_map[j]] && !i_analog_en[in_map[j]];
      end
    end
  end

  // Pad priority: fixed special, then mapped output, then port data
  always_comb begin
    next_pad_out = '0;
    next_pad_oe_n = '1;
    for (int p = 0; p < prc_pkg::NUM_RP; p++) begin
      if (i_special_en[p]) begin
        next_pad_out[p] = i_special_out[p];
      end else if (out_map[p] != prc_pkg::OUT_NULL) begin
        next_pad_out[p] = i_periph_out[out_map[p]];
      end else begin
        next_pad_out[p] = i_gpio_out[p];
      end
      next_pad_oe_n[p] = !i_special_en[p] && i_dir_in[p];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_periph_in <= '0;
      o_pad_out <= '0;
      o_pad_oe_n <= '1;
    end else if (i_ce) begin
      o_periph_in <= next_periph_in;
      o_pad_out <= next_pad_out;
      o_pad_oe_n <= next_pad_oe_n;
    end
  end

  // Change-notice pins stay on fixed pads, outside the remap path
  prc_cn_cell #(
    .W(prc_pkg::NUM_CN_LOW)
  ) u_cn_low (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_pad(i_cn_pad[prc_pkg::NUM_CN_LOW-1:0]),
    .i_en(i_change_enable_low),
    .o_hit(hit_low)
  );

  prc_cn_cell #(
    .W(prc_pkg::NUM_CN_HIGH)
  ) u_cn_high (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_pad(i_cn_pad[prc_pkg::NUM_CN-1:prc_pkg::NUM_CN_LOW]),
    .i_en(i_change_enable_high),
    .o_hit(hit_high)
  );

  assign cn_hit = {hit_high, hit_low};

  // Shared flag; a new change wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cn_flag <= prc_pkg::FLAG_RST;
    end else if (i_ce) begin
      if (|cn_hit) begin
        o_cn_flag <= 1'b1;
      end else if (i_cn_flag_clr) begin
        o_cn_flag <= 1'b0;
      end
    end
  end

  // Software must clear a pull-up bit when its pin is an output
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pullup_en <= '0;
    end else if (i_ce) begin
      o_pullup_en <= {i_pullup_enable_high, i_pullup_enable_low};
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_change;
    i_ce && (|cn_hit);
  endsequence

  sequence s_quiet;
    !(|cn_hit);
  endsequence

  a_reset_map_values: assert property ($past(i_rst) |-> (in_map[0] == prc_pkg::IN_MAP_RST
    && out_map[prc_pkg::NUM_RP-1] == prc_pkg::OUT_MAP_RST && o_periph_in == '0))
    else $error("mapping fields not at reset values");

  a_reset_unlocked: assert property ($past(i_rst) |-> !o_lock)
    else $error("lock not clear after reset");

  a_locked_map_hold: assert property (o_lock |=> ($stable(in_map[0]) && $stable(out_map[0])))
    else $error("mapping changed while locked");

  a_cn_flag_set: assert property (s_change |=> o_cn_flag)
    else $error("change did not set flag");

  a_cn_flag_cause: assert property ($rose(o_cn_flag) |-> $past(|cn_hit && i_ce))
    else $error("flag rose without enabled change");

  a_cn_flag_clear: assert property (o_cn_flag && i_ce && i_cn_flag_clr ##0 s_quiet
    |=> !o_cn_flag)
    else $error("flag clear ignored");

  a_pullup_follow: assert property (i_ce |=> o_pullup_en ==
    $past({i_pullup_enable_high, i_pullup_enable_low}))
    else $error("pull-up output mismatch");

  a_special_first: assert property (i_ce && i_special_en[0] |=>
    (o_pad_out[0] == $past(i_special_out[0]) && !o_pad_oe_n[0]))
    else $error("special output lost priority");

  a_mapped_output: assert property (i_ce && !i_special_en[1] && out_map[1] != prc_pkg::OUT_NULL
    |=> o_pad_out[1] == $past(i_periph_out[out_map[1]]))
    else $error("mapped output not on pad");

  a_null_output: assert property (i_ce && !i_special_en[2] && out_map[2] == prc_pkg::OUT_NULL
    |=> o_pad_out[2] == $past(i_gpio_out[2]))
    else $error("null mapping did not pass port data");

  a_input_no_drive: assert property (i_ce && !i_special_en[3] |=>
    o_pad_oe_n[3] == $past(i_dir_in[3]))
    else $error("mapped input touched output buffer");

  a_analog_blocks: assert property (i_ce && in_map[0] < RP_LIMIT && i_analog_en[in_map[0]]
    |=> !o_periph_in[0])
    else $error("analog pin reached peripheral input");

  a_tied_low_input: assert property (i_ce && in_map[1] >= RP_LIMIT |=> !o_periph_in[1])
    else $error("unassigned input not tied low");
endmodule
`default_nettype wire
